// [dv/hbis_lnk_checker.sv]
// Purpose: Pin checks on the host to display link
// Assumes: One reset serves both ends
// Notes:   Sampled on the link clock
`timescale 1ns/1ps
`default_nettype none

module hbis_lnk_checker (
  input wire logic       lnk_clk_i,
  input wire logic       resetn_i,
  input wire logic [2:0] im,
  input wire logic       cs_n,
  input wire logic       e_rd,
  input wire logic       rw_wr,
  input wire logic [7:0] d_host_oe,
  input wire logic [7:0] d_dev_oe
);
  default clocking cb @(posedge lnk_clk_i); endclocking
  default disable iff (!resetn_i);

  // ****************************************
  // Pin drive rules
  // ****************************************
  property p_dsel_hz; |d_dev_oe |-> !cs_n; endproperty
  a_dsel_hz: assert property (p_dsel_hz)
    else $error("device drives while deselected");
  property p_ser_hz; im[1] |-> ((d_dev_oe | d_host_oe) & 8'hfc) == 8'h00; endproperty
  a_ser_hz: assert property (p_ser_hz)
    else $error("upper pins driven in serial mode");
  property p_ser_nord; im[1] |-> d_dev_oe == 8'h00; endproperty
  a_ser_nord: assert property (p_ser_nord)
    else $error("device read drive in serial mode");
  property p_nib_hz; im[2:1] == 2'b10 |-> ((d_dev_oe | d_host_oe) & 8'h0f) == 8'h00; endproperty
  a_nib_hz: assert property (p_nib_hz)
    else $error("low pins driven in nibble mode");
  property p_rd80; $rose(|d_dev_oe) && im[1:0] == 2'b01 |-> $past(!e_rd && !cs_n, 2); endproperty
  a_rd80: assert property (p_rd80)
    else $error("read drive without read strobe");
  property p_rd68; $rose(|d_dev_oe) && im[1:0] == 2'b00 |-> $past(e_rd && rw_wr && !cs_n, 2); endproperty
  a_rd68: assert property (p_rd68)
    else $error("read drive without enable and read level");
  property p_wr80; im[1:0] == 2'b01 && !rw_wr |-> d_dev_oe == 8'h00; endproperty
  a_wr80: assert property (p_wr80)
    else $error("device drives during write strobe");
  property p_spi_tie; im == 3'h2 |-> e_rd && rw_wr; endproperty
  a_spi_tie: assert property (p_spi_tie)
    else $error("strobes not tied in serial mode");
endmodule : hbis_lnk_checker

`default_nettype wire

// [dv/tb.sv]
// Purpose: Both ends joined, every strap code exercised
// Assumes: Straps change only while idle
// Notes:   Random bytes from a fixed seed
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic       clk_i, lnk_clk, resetn, req, req_rd, req_rs, busy, vld, ram_we, cmd_we, ram_re;
  logic [2:0] mode;
  logic [7:0] req_data, rdata, wdata, ram_rdata, status, rbuf_exp;
  int         failures, comparisons, seed, cyc, n_ram, n_cmd, n_re, n_vld;

  hbis_if i_hbis_if ();
  hbis_host i_hbis_host (.clk_i(clk_i), .resetn_i(resetn), .mode_i(mode), .req_i(req),
    .req_rd_i(req_rd), .req_rs_i(req_rs), .req_data_i(req_data), .busy_o(busy),
    .rdata_o(rdata), .rdata_vld_o(vld), .lnk(i_hbis_if));
  hbis_dev i_hbis_dev (.lnk_clk_i(lnk_clk), .resetn_i(resetn), .lnk(i_hbis_if),
    .ram_rdata_i(ram_rdata), .status_i(status), .wdata_o(wdata), .ram_we_o(ram_we),
    .cmd_we_o(cmd_we), .ram_re_o(ram_re));
  hbis_lnk_checker i_hbis_lnk_checker (.lnk_clk_i(lnk_clk), .resetn_i(resetn),
    .im(i_hbis_if.im), .cs_n(i_hbis_if.cs_n), .e_rd(i_hbis_if.e_rd), .rw_wr(i_hbis_if.rw_wr),
    .d_host_oe(i_hbis_if.d_host_oe), .d_dev_oe(i_hbis_if.d_dev_oe));

  // Clocks, link clock unrelated in phase
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    lnk_clk = 1'b0;
    #3;
    forever #6 lnk_clk = ~lnk_clk;
  end

  // Count write and RAM fetch pulses from the device
  always @(posedge lnk_clk) begin
    if (ram_we === 1'b1) n_ram <= n_ram + 1;
    if (cmd_we === 1'b1) n_cmd <= n_cmd + 1;
    if (ram_re === 1'b1) n_re <= n_re + 1;
  end

  // Hang guard, read result pulses counted
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (vld === 1'b1) n_vld <= n_vld + 1;
    if (cyc == 6000) begin
      failures++;
      results();
    end
  end

  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chkb(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chkb

  // Accepted requests: parallel modes, 4-wire serial writes only
  function automatic logic takes(input logic [2:0] m, input logic rd);
    return !m[1] || (m == 3'h2 && !rd);
  endfunction : takes

  // One request, then checks on pulses and data
  task automatic run(input logic rd, input logic rs, input logic [7:0] dat);
    int   r0;
    int   c0;
    int   e0;
    int   v0;
    logic seen;
    logic ok;
    r0 = n_ram;
    c0 = n_cmd;
    e0 = n_re;
    v0 = n_vld;
    seen = 1'b0;
    ok = takes(mode, rd);
    @(posedge clk_i);
    req_rd <= rd;
    req_rs <= rs;
    req_data <= dat;
    req <= 1'b1;
    @(posedge clk_i);
    req <= 1'b0;
    #1;
    while (busy !== 1'b0) begin
      seen = 1'b1;
      @(posedge clk_i);
      #1;
    end
    repeat (6) @(posedge clk_i);
    chkb(seen, ok);
    chk8(8'(n_ram - r0), {7'h0, ok & !rd & rs});
    chk8(8'(n_cmd - c0), {7'h0, ok & !rd & !rs});
    if (ok && !rd) chk8(wdata, dat);
    if (ok && rd && !rs) chk8(rdata, status);
    if (ok && rd && rs) chk8(rdata, rbuf_exp);
    chk8(8'(n_re - e0), {7'h0, ok & rd & rs});
    chk8(8'(n_vld - v0), {7'h0, ok & rd});
    // Buffer now holds the byte fetched after this read
    if (ok && rd && rs) rbuf_exp = ram_rdata;
  endtask : run

  // Main sequence over all strap codes
  initial begin
    seed = 98;
    {failures, comparisons, cyc, n_ram, n_cmd, n_re, n_vld} = '0;
    {resetn, req, req_rd, req_rs} = '0;
    {mode, req_data, ram_rdata, status, rbuf_exp} = '0;
    repeat (2) @(posedge clk_i);
    resetn <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      @(posedge clk_i);
      mode <= 3'(m);
      status <= 8'($random(seed));
      ram_rdata <= 8'($random(seed));
      repeat (8) @(posedge clk_i);
      run(1'b0, 1'b1, 8'h01);
      run(1'b0, 1'b0, 8'($random(seed)));
      run(1'b0, 1'b1, 8'($random(seed)));
      run(1'b1, 1'b0, 8'h00);
      run(1'b1, 1'b1, 8'h00);
      run(1'b1, 1'b1, 8'h00);
      if (!m[1]) chk8(rdata, ram_rdata);
      $display("mode %0d done", m);
    end
    results();
  end
endmodule : tb

`default_nettype wire

// [rtl/hbis_consts.svh]
// Purpose: Constants shared by both ends of the host bus interface select block
// Assumes: Included by bare name after the package
// Notes:   Times in ns, cycle counts derived from the 50 MHz host clock
`ifndef HBIS_CONSTS_SVH
`define HBIS_CONSTS_SVH

// ****************************************
// Interface select strap codes
// ****************************************
`define HBIS_M_6800_8  3'h0
`define HBIS_M_8080_8  3'h1
`define HBIS_M_SPI4    3'h2
`define HBIS_M_I2C_A   3'h3
`define HBIS_M_6800_4  3'h4
`define HBIS_M_8080_4  3'h5
`define HBIS_M_SPI3    3'h6
`define HBIS_M_I2C_B   3'h7

// ****************************************
// Data pin enable masks
// ****************************************
`define HBIS_OE_BYTE   8'hff
`define HBIS_OE_NIB    8'hf0
`define HBIS_OE_SER    8'h03
`define HBIS_OE_NONE   8'h00

// ****************************************
// Host timing, least times round up
// ****************************************
`define HBIS_CLK_NS    20
`define HBIS_SETUP_NS  40
`define HBIS_STB_NS    160
`define HBIS_HOLD_NS   80
`define HBIS_SETUP_CYC ((`HBIS_SETUP_NS + `HBIS_CLK_NS - 1) / `HBIS_CLK_NS)
`define HBIS_STB_CYC   ((`HBIS_STB_NS + `HBIS_CLK_NS - 1) / `HBIS_CLK_NS)
`define HBIS_HOLD_CYC  ((`HBIS_HOLD_NS + `HBIS_CLK_NS - 1) / `HBIS_CLK_NS)
`define HBIS_SPI_BITS  3'h7

`endif

// [rtl/hbis_dev.sv]
// Purpose: Display controller host front end (parallel and 4-wire serial)
// Assumes: lnk_clk_i is the device core clock; all pins are asynchronous
// Notes:   3-wire serial and two-wire bus engines are not present here
// What this block does
// - Straps select bus type and width
// - Serial modes float D7-D2, D1 data, D0 clock
// - Nibble modes use D7-D4, float D3-D0
// - 6800 read/write level picks direction
// - 6800 enable high with chip select latches
// - Display reads pipelined, first read is dummy
// - 8080 read strobe low drives data/status
// - 8080 write strobe low writes data/command
// - Select plus direction decode four functions
// - Serial data shifts MSB first on rise
// - Eighth serial clock samples select, writes
// - Deselected serial port ignores clock, data
// - Chip select fall starts serial bit count
// - Serial works with select held low
// - Deselect clears shifter and bit counter
// - Serial modes have no read path
// - Host ties unused strobes in serial mode
// - 8080 write data taken at strobe rise
// - Deselected device floats all data pins
`timescale 1ns/1ps
`default_nettype none

module hbis_dev
  import hbis_pkg::*;
(
  input  wire logic       lnk_clk_i,     // Device core clock
  input  wire logic       resetn_i,      // Async reset, active low
  hbis_if.dev             lnk,           // Host pins
  input  wire logic [7:0] ram_rdata_i,   // RAM data, valid cycle after read
  input  wire logic [7:0] status_i,      // Status byte
  output logic      [7:0] wdata_o,       // Write byte
  output logic            ram_we_o,      // Display RAM write pulse
  output logic            cmd_we_o,      // Command write pulse
  output logic            ram_re_o       // Display RAM fetch pulse
);
  `include "hbis_consts.svh"

  // ****************************************
  // Synchronised pins
  // ****************************************
  logic [15:0] pin_raw;   // Pins as they arrive
  logic [15:0] pin_syn;   // Pins after two flops
  logic [2:0]  im;        // Straps
  logic        cs_n;      // Chip select
  logic        dcs;       // Data/command select
  logic        pa;        // Enable or read strobe
  logic        pb;        // Read/write or write strobe
  logic [7:0]  din;       // Data pins

  assign pin_raw = {1'b0, lnk.im, lnk.cs_n, lnk.data_command_select, lnk.e_rd, lnk.rw_wr, lnk.d};

  hbis_sync #(.W(16)) u_sync (
    .clk_i    (lnk_clk_i),
    .resetn_i (resetn_i),
    .d_i      (pin_raw),
    .q_o      (pin_syn)
  );

  assign im   = pin_syn[14:12];
  assign cs_n = pin_syn[11];
  assign dcs  = pin_syn[10];
  assign pa   = pin_syn[9];
  assign pb   = pin_syn[8];
  assign din  = pin_syn[7:0];

  // ****************************************
  // Mode decode
  // ****************************************
  logic is68;   // 6800 style
  logic is80;   // 8080 style
  logic nibm;   // Nibble width
  logic spi4;   // 4-wire serial
  logic act;    // Parallel strobe active
  logic rdsel;  // Current access is a read

  always_comb begin
    is68  = (im == `HBIS_M_6800_8) || (im == `HBIS_M_6800_4);
    is80  = (im == `HBIS_M_8080_8) || (im == `HBIS_M_8080_4);
    nibm  = (im == `HBIS_M_6800_4) || (im == `HBIS_M_8080_4);
    spi4  = (im == `HBIS_M_SPI4);
    // enable high qualified by chip select
    // low strobes qualified by chip select
    act   = !cs_n && ((is68 && pa) || (is80 && (!pa || !pb)));
    rdsel = is68 ? pb : !pa;
  end

  // ****************************************
  // State registers
  // ****************************************
  logic       act_r, act_nxt;       // Strobe seen last cycle
  logic       rd_r, rd_nxt;         // Access is a read
  logic       rsrd_r, rsrd_nxt;     // Read targets display data
  logic       lo_r, lo_nxt;         // Second nibble pending
  logic [3:0] whi_r, whi_nxt;       // First written nibble
  logic [7:0] obyte_r, obyte_nxt;   // Byte being read out
  logic [7:0] rbuf_r, rbuf_nxt;     // Pipelined RAM read buffer
  logic       fill_r, fill_nxt;     // RAM data lands this cycle
  logic [7:0] dout_r, dout_nxt;     // Pin data drive
  logic [7:0] doe_r, doe_nxt;       // Pin drive enables
  logic [7:0] sh_r, sh_nxt;         // Serial shifter
  logic [2:0] bc_r, bc_nxt;         // Serial bit count
  logic       sck_r, sck_nxt;       // Last serial clock level
  logic [7:0] wd_r, wd_nxt;         // Write byte
  logic       rwe_r, rwe_nxt;       // RAM write pulse
  logic       cwe_r, cwe_nxt;       // Command write pulse
  logic       rre_r, rre_nxt;       // RAM fetch pulse

  logic [7:0] wbyte;  // Assembled parallel byte
  logic       fin;    // Strobe just ended
  logic [7:0] sbyte;  // Assembled serial byte

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    act_nxt   = act;
    rd_nxt    = rd_r;
    rsrd_nxt  = rsrd_r;
    lo_nxt    = lo_r;
    whi_nxt   = whi_r;
    obyte_nxt = obyte_r;
    rbuf_nxt  = rbuf_r;
    fill_nxt  = 1'b0;
    wd_nxt    = wd_r;
    rwe_nxt   = 1'b0;
    cwe_nxt   = 1'b0;
    rre_nxt   = 1'b0;
    sh_nxt    = sh_r;
    bc_nxt    = bc_r;
    sck_nxt   = din[0];
    fin       = act_r && !act;
    wbyte     = nibm ? {whi_r, din[7:4]} : din;
    sbyte     = {sh_r[6:0], din[1]};

    // Start of a parallel access
    if (act && !act_r) begin
      rd_nxt = rdsel;
      if (rdsel && !lo_r) begin
        // select high reads RAM, low reads status
        rsrd_nxt  = dcs;
        obyte_nxt = dcs ? rbuf_r : status_i;
      end
    end

    // End of a parallel access
    if (fin) begin
      if (nibm && !lo_r) begin
        lo_nxt = 1'b1;
        if (!rd_r) begin
          whi_nxt = din[7:4];
        end
      end else begin
        lo_nxt = 1'b0;
        if (rd_r) begin
          // refill buffer after each data read
          rre_nxt = rsrd_r;
        end else begin
          wd_nxt  = wbyte;
          rwe_nxt = dcs;
          cwe_nxt = !dcs;
        end
      end
    end

    // fetched RAM data lands in buffer
    fill_nxt = rre_r;
    if (fill_r) begin
      rbuf_nxt = ram_rdata_i;
    end

    // deselect holds serial port at rest
    if (cs_n || !spi4) begin
      sh_nxt = 8'h00;
      bc_nxt = 3'h0;
    end else if (din[0] && !sck_r) begin
      sh_nxt = sbyte;
      bc_nxt = bc_r + 3'h1;
      if (bc_r == `HBIS_SPI_BITS) begin
        bc_nxt  = 3'h0;
        wd_nxt  = sbyte;
        rwe_nxt = dcs;
        cwe_nxt = !dcs;
      end
    end

    // pins float unless reading while selected
    // nibble modes drive only upper pins
    doe_nxt  = `HBIS_OE_NONE;
    dout_nxt = 8'h00;
    if (act && rd_nxt && (is68 || is80)) begin
      doe_nxt  = nibm ? `HBIS_OE_NIB : `HBIS_OE_BYTE;
      dout_nxt = nibm ? {(lo_r ? obyte_nxt[3:0] : obyte_nxt[7:4]), 4'h0} : obyte_nxt;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge lnk_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      act_r   <= 1'b0;
      rd_r    <= 1'b0;
      rsrd_r  <= 1'b0;
      lo_r    <= 1'b0;
      whi_r   <= 4'h0;
      obyte_r <= 8'h00;
      rbuf_r  <= 8'h00;
      fill_r  <= 1'b0;
      dout_r  <= 8'h00;
      doe_r   <= 8'h00;
      sh_r    <= 8'h00;
      bc_r    <= 3'h0;
      sck_r   <= 1'b0;
      wd_r    <= 8'h00;
      rwe_r   <= 1'b0;
      cwe_r   <= 1'b0;
      rre_r   <= 1'b0;
    end else begin
      act_r   <= act_nxt;
      rd_r    <= rd_nxt;
      rsrd_r  <= rsrd_nxt;
      lo_r    <= lo_nxt;
      whi_r   <= whi_nxt;
      obyte_r <= obyte_nxt;
      rbuf_r  <= rbuf_nxt;
      fill_r  <= fill_nxt;
      dout_r  <= dout_nxt;
      doe_r   <= doe_nxt;
      sh_r    <= sh_nxt;
      bc_r    <= bc_nxt;
      sck_r   <= sck_nxt;
      wd_r    <= wd_nxt;
      rwe_r   <= rwe_nxt;
      cwe_r   <= cwe_nxt;
      rre_r   <= rre_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign lnk.d_dev    = dout_r;
  assign lnk.d_dev_oe = doe_r;
  assign wdata_o      = wd_r;
  assign ram_we_o     = rwe_r;
  assign cmd_we_o     = cwe_r;
  assign ram_re_o     = rre_r;
endmodule : hbis_dev

`default_nettype wire

// [rtl/hbis_host.sv]
// Purpose: Host end driving the parallel or 4-wire serial display bus
// Assumes: clk_i at 50 MHz; mode_i static during a request
// Notes:   Serial clock made by dividing clk_i; serial reads refused
`timescale 1ns/1ps
`default_nettype none

module hbis_host
  import hbis_pkg::*;
(
  input  wire logic       clk_i,        // Host clock
  input  wire logic       resetn_i,     // Async reset, active low
  input  wire logic [2:0] mode_i,       // Strap code to drive
  input  wire logic       req_i,        // Transfer request
  input  wire logic       req_rd_i,     // Read when high
  input  wire logic       req_rs_i,     // Data high, command low
  input  wire logic [7:0] req_data_i,   // Write byte
  output logic            busy_o,       // Transfer in progress
  output logic      [7:0] rdata_o,      // Read byte
  output logic            rdata_vld_o,  // Read byte valid pulse
  hbis_if.host            lnk           // Device pins
);
  `include "hbis_consts.svh"

  logic [7:0] dsyn;  // Data pins after two flops

  // Pins from the device domain
  hbis_sync #(.W(8)) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      (lnk.d),
    .q_o      (dsyn)
  );

  // ****************************************
  // Mode decode
  // ****************************************
  logic is68;  // 6800 style
  logic par;   // Parallel mode
  logic nibm;  // Nibble width
  logic spi4;  // 4-wire serial

  always_comb begin
    is68 = (mode_i == `HBIS_M_6800_8) || (mode_i == `HBIS_M_6800_4);
    nibm = (mode_i == `HBIS_M_6800_4) || (mode_i == `HBIS_M_8080_4);
    par  = is68 || nibm || (mode_i == `HBIS_M_8080_8);
    spi4 = (mode_i == `HBIS_M_SPI4);
  end

  // ****************************************
  // Sequencer state
  // ****************************************
  hbis_state_type st_r, st_nxt;  // Sequencer state
  logic [3:0] cnt_r, cnt_nxt;    // Phase timer
  logic [2:0] bit_r, bit_nxt;    // Serial bit index
  logic       rd_r, rd_nxt;      // Read in progress
  logic       lo_r, lo_nxt;      // Second nibble phase
  logic [7:0] byte_r, byte_nxt;  // Byte to send
  logic [7:0] rdat_r, rdat_nxt;  // Read result
  logic       vld_r, vld_nxt;    // Read result pulse
  logic       cs_r, cs_nxt;      // Chip select pin
  logic       rs_r, rs_nxt;      // Select pin
  logic       a_r, a_nxt;        // Enable or read strobe pin
  logic       b_r, b_nxt;        // Read/write or write strobe pin
  logic [7:0] do_r, do_nxt;      // Data drive
  logic [7:0] oe_r, oe_nxt;      // Data drive enables

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r + 4'h1;
    bit_nxt  = bit_r;
    rd_nxt   = rd_r;
    lo_nxt   = lo_r;
    byte_nxt = byte_r;
    rdat_nxt = rdat_r;
    vld_nxt  = 1'b0;
    cs_nxt   = cs_r;
    rs_nxt   = rs_r;
    a_nxt    = a_r;
    b_nxt    = b_r;
    do_nxt   = do_r;
    oe_nxt   = oe_r;
    case (st_r)
      HBIS_IDLE: begin
        cnt_nxt = 4'h0;
        a_nxt   = !is68;
        b_nxt   = 1'b1;
        if (req_i && (par || (spi4 && !req_rd_i))) begin
          // select falls to open a transfer
          st_nxt   = HBIS_SETUP;
          cs_nxt   = 1'b0;
          rs_nxt   = req_rs_i;
          rd_nxt   = req_rd_i;
          lo_nxt   = 1'b0;
          byte_nxt = req_data_i;
          bit_nxt  = 3'h0;
          if (spi4) begin
            oe_nxt = `HBIS_OE_SER;
            do_nxt = {6'h00, req_data_i[7], 1'b0};
          end else begin
            b_nxt  = is68 ? req_rd_i : 1'b1;
            oe_nxt = req_rd_i ? `HBIS_OE_NONE : (nibm ? `HBIS_OE_NIB : `HBIS_OE_BYTE);
            do_nxt = nibm ? {req_data_i[7:4], 4'h0} : req_data_i;
          end
        end
      end
      HBIS_SETUP: begin
        if (cnt_r == 4'(`HBIS_SETUP_CYC - 1)) begin
          cnt_nxt = 4'h0;
          if (spi4) begin
            st_nxt = HBIS_SLO;
          end else begin
            st_nxt = HBIS_STROBE;
            a_nxt  = is68 ? 1'b1 : !rd_r;
            b_nxt  = is68 ? rd_r : rd_r;
          end
        end
      end
      HBIS_STROBE: begin
        if (cnt_r == 4'(`HBIS_STB_CYC - 1)) begin
          cnt_nxt = 4'h0;
          st_nxt  = HBIS_HOLD;
          a_nxt   = !is68;
          b_nxt   = is68 ? rd_r : 1'b1;
          if (rd_r) begin
            rdat_nxt = !nibm ? dsyn : (lo_r ? {rdat_r[7:4], dsyn[7:4]} : {dsyn[7:4], 4'h0});
          end
        end
      end
      HBIS_HOLD: begin
        if (cnt_r == 4'(`HBIS_HOLD_CYC - 1)) begin
          cnt_nxt = 4'h0;
          if (par && nibm && !lo_r) begin
            lo_nxt = 1'b1;
            do_nxt = {byte_r[3:0], 4'h0};
            st_nxt = HBIS_SETUP;
          end else begin
            st_nxt  = HBIS_IDLE;
            cs_nxt  = 1'b1;
            oe_nxt  = `HBIS_OE_NONE;
            vld_nxt = rd_r;
          end
        end
      end
      HBIS_SLO: begin
        // Serial clock low half
        if (cnt_r == 4'(`HBIS_STB_CYC - 1)) begin
          cnt_nxt = 4'h0;
          st_nxt  = HBIS_SHI;
          do_nxt  = {6'h00, byte_r[7], 1'b1};
        end
      end
      HBIS_SHI: begin
        // Serial clock high half, next bit after fall
        if (cnt_r == 4'(`HBIS_STB_CYC - 1)) begin
          cnt_nxt  = 4'h0;
          bit_nxt  = bit_r + 3'h1;
          byte_nxt = {byte_r[6:0], 1'b0};
          do_nxt   = {6'h00, byte_r[6], 1'b0};
          st_nxt   = (bit_r == `HBIS_SPI_BITS) ? HBIS_HOLD : HBIS_SLO;
        end
      end
      default: begin
        st_nxt = HBIS_IDLE;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r   <= HBIS_IDLE;
      cnt_r  <= 4'h0;
      bit_r  <= 3'h0;
      rd_r   <= 1'b0;
      lo_r   <= 1'b0;
      byte_r <= 8'h00;
      rdat_r <= 8'h00;
      vld_r  <= 1'b0;
      cs_r   <= 1'b1;
      rs_r   <= 1'b0;
      a_r    <= 1'b1;
      b_r    <= 1'b1;
      do_r   <= 8'h00;
      oe_r   <= 8'h00;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      bit_r  <= bit_nxt;
      rd_r   <= rd_nxt;
      lo_r   <= lo_nxt;
      byte_r <= byte_nxt;
      rdat_r <= rdat_nxt;
      vld_r  <= vld_nxt;
      cs_r   <= cs_nxt;
      rs_r   <= rs_nxt;
      a_r    <= a_nxt;
      b_r    <= b_nxt;
      do_r   <= do_nxt;
      oe_r   <= oe_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign busy_o                  = (st_r != HBIS_IDLE);
  assign rdata_o                 = rdat_r;
  assign rdata_vld_o             = vld_r;
  assign lnk.im                  = mode_i;
  assign lnk.cs_n                = cs_r;
  assign lnk.data_command_select = rs_r;
  assign lnk.e_rd                = a_r;
  assign lnk.rw_wr               = b_r;
  assign lnk.d_host              = do_r;
  assign lnk.d_host_oe           = oe_r;
endmodule : hbis_host

`default_nettype wire

// [rtl/hbis_if.sv]
// Purpose: Pin level link between host and display front end
// Assumes: Undriven data lines float high
// Notes:   Resolves the shared data wires from the two enables
`timescale 1ns/1ps
`default_nettype none

interface hbis_if;
  logic [2:0] im;        // Interface select straps
  logic       cs_n;      // Chip select, active low
  logic       data_command_select; // High data, low command
  logic       e_rd;      // 6800 enable or 8080 read strobe
  logic       rw_wr;     // 6800 read/write or 8080 write strobe
  logic [7:0] d_host;    // Host data drive
  logic [7:0] d_host_oe; // Host drive enables
  logic [7:0] d_dev;     // Device data drive
  logic [7:0] d_dev_oe;  // Device drive enables
  logic [7:0] d;         // Resolved data wires

  // Device wins, then host, else the line floats high
  assign d = (d_dev_oe & d_dev) | (~d_dev_oe & d_host_oe & d_host) | (~d_dev_oe & ~d_host_oe);

  modport dev (input im, cs_n, data_command_select, e_rd, rw_wr, d, output d_dev, d_dev_oe);
  modport host (output im, cs_n, data_command_select, e_rd, rw_wr, d_host, d_host_oe, input d);
endinterface : hbis_if

`default_nettype wire

// [rtl/hbis_pkg.sv]
// Purpose: Types of the host bus interface select block
// Assumes: Nothing
// Notes:   Constants live in hbis_consts.svh
package hbis_pkg;

  // ****************************************
  // Host sequencer states, Gray along the byte-wide parallel path
  // ****************************************
  typedef enum logic [2:0] {
    HBIS_IDLE   = 3'h0,  // Bus released
    HBIS_SETUP  = 3'h1,  // Select and data settle
    HBIS_STROBE = 3'h3,  // Strobe asserted
    HBIS_HOLD   = 3'h2,  // Strobe released, data held
    HBIS_SLO    = 3'h5,  // Serial clock low half
    HBIS_SHI    = 3'h7   // Serial clock high half
  } hbis_state_type;

endpackage : hbis_pkg

// [rtl/hbis_sync.sv]
// Purpose: Two flop synchroniser for a group of pin levels
// Assumes: Inputs are levels from another clock domain
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module hbis_sync #(
  parameter int W = 8  // Number of levels
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;  // First stage
  logic [W-1:0] q_r;     // Second stage

  // ****************************************
  // Two stage capture
  // ****************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= d_i;
      q_r    <= meta_r;
    end
  end

  assign q_o = q_r;
endmodule : hbis_sync

`default_nettype wire
